/* File: hdl/cfg_field_pkg.sv */
// constants and types for the configuration field bank
// What this block does
// - immediate set of line rate takes effect at once; codes 2,3,5,6 valid.
// - filter fields map value ranges to 5, 10, 20 or 50 Hz cutoff.
// - continuous packet field holds the repeatedly sent packet type, variant dependent.
// - orientation bits 0, 3, 6 are X, Y, Z signs; one means negative.
// - orientation bits 2:1 pick sensor axis for user X; code 3 invalid.
// - orientation bits 5:4 pick sensor axis for user Y, rotated; code 3 invalid.
// - orientation bits 8:7 pick sensor axis for user Z; bits 15:9 reserved.
// - only the 24 listed orientation values accepted; others nak, no change.
// - default orientation is minus first, minus second, plus third axis.
// - switch bit 0 one selects free inertial integration for 60 seconds.
// - switch bit 4 one restarts the system after a sensor over-range.
// - switch bit 5 zero static high gain; one dynamic nominal gain.
// - alarm fields 0x0029 to 0x0031; roll limits accept -25 to +25 degrees.
// - power-up loads stored values; set changes working, write changes stored.
package cfg_field_pkg;
   localparam logic [15:0] FLD_RATE_DIV   = 16'h0001;
   localparam logic [15:0] FLD_LINE_RATE  = 16'h0002;
   localparam logic [15:0] FLD_PKT_SEL    = 16'h0003;
   localparam logic [15:0] FLD_UNUSED     = 16'h0004;
   localparam logic [15:0] FLD_RATE_FILT  = 16'h0005;
   localparam logic [15:0] FLD_ACC_FILT   = 16'h0006;
   localparam logic [15:0] FLD_ORIENT     = 16'h0007;
   localparam logic [15:0] FLD_SWITCHES   = 16'h0008;
   localparam logic [15:0] FLD_ALARM_LO   = 16'h0029;
   localparam logic [15:0] FLD_ALARM_HI   = 16'h0031;
   localparam logic [15:0] FLD_ROLL_UP    = 16'h0029;
   localparam logic [15:0] FLD_ROLL_DN    = 16'h002A;
   localparam int          NUM_SLOTS      = 18;
   localparam logic [15:0] ORIENT_RST     = 16'h0009;
   localparam logic [15:0] FILT_5HZ_MIN   = 16'h1BE6;  // 7142
   localparam logic [15:0] FILT_10HZ_MIN  = 16'h0DF3;  // 3571
   localparam logic [15:0] FILT_20HZ_MIN  = 16'h05FA;  // 1530
   localparam logic [15:0] ROLL_MAX       = 16'h0019;  // +25 deg
   localparam logic [15:0] ROLL_MIN       = 16'hFFE7;  // -25 deg
   localparam int          SW_FREE_BIT    = 0;
   localparam int          SW_RESTART_BIT = 4;
   localparam int          SW_DYNAMIC_BIT = 5;
   localparam int          FREE_TIME_S    = 60;
   localparam int          CLK_HZ         = 50_000_000;
   localparam longint      FREE_CYCLES    = longint'(FREE_TIME_S) * CLK_HZ;

   typedef enum logic [1:0] {
      CUT_50HZ = 2'b00,
      CUT_20HZ = 2'b01,
      CUT_10HZ = 2'b11,
      CUT_5HZ  = 2'b10
   } cutoff_e;

   typedef enum logic [1:0] {
      AX_ONE   = 2'd0,
      AX_TWO   = 2'd1,
      AX_THREE = 2'd2,
      AX_NONE  = 2'd3
   } sensor_axis_e;

   typedef struct packed {
      logic        valid;
      logic        persistent;
      logic [15:0] field_id;
      logic [15:0] data;
   } field_req_s;

   typedef struct packed {
      logic        valid;
      logic        ack;
      logic [15:0] field_id;
      logic [15:0] data;
   } field_rsp_s;

   typedef struct packed {
      logic         x_neg;
      sensor_axis_e x_src;
      logic         y_neg;
      sensor_axis_e y_src;
      logic         z_neg;
      sensor_axis_e z_src;
   } axis_map_s;
endpackage

/* File: hdl/sensor_config_field_bank.sv */
// configuration field bank: validation, working and stored copies, decode
`timescale 1ns/100ps
`default_nettype none
module sensor_config_field_bank
   import cfg_field_pkg::*;
#(
   parameter longint FREE_RUN_CYCLES = FREE_CYCLES
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_b,
   // power-up load from nonvolatile storage
   input  wire logic         load_valid,
   input  wire logic [15:0]  load_field_id,
   input  wire logic [15:0]  load_data,
   // command side
   input  wire field_req_s   set_req,
   input  wire logic         read_req,
   input  wire logic         read_stored,
   input  wire logic [15:0]  read_field_id,
   output field_rsp_s        rsp,
   // persistent write toward storage
   output logic              store_valid,
   output logic [15:0]       store_field_id,
   output logic [15:0]       store_data,
   // packet type acceptance from product variant
   input  wire logic         pkt_type_ok,
   // algorithm events
   input  wire logic         over_range,
   // decoded configuration
   output logic [15:0]       rate_divider,
   output logic [2:0]        line_rate_code,
   output logic              line_rate_change,
   output logic [15:0]       packet_select,
   output cutoff_e           rate_filter_setting,
   output cutoff_e           accel_filter_setting,
   output axis_map_s         axis_map,
   output logic              free_integrate,
   output logic              restart_req,
   output logic              high_gain,
   output logic [15:0]       roll_upper,
   output logic [15:0]       roll_lower
);
   localparam int          CNT_W      = 32;
   localparam logic [4:0]  ROLL_UP_SLOT = 5'd9 + 5'(FLD_ROLL_UP - FLD_ALARM_LO);
   localparam logic [4:0]  ROLL_DN_SLOT = 5'd9 + 5'(FLD_ROLL_DN - FLD_ALARM_LO);
   localparam logic [CNT_W-1:0] FREE_LAST = CNT_W'(FREE_RUN_CYCLES - 1);

   // slot 1..8 basic fields, 9..17 alarm fields 0x29..0x31; slot 0 never used
   logic [15:0] work_reg  [NUM_SLOTS];
   logic [15:0] store_reg [NUM_SLOTS];

   function automatic logic [4:0] slot_of(input logic [15:0] id);
      if (id >= FLD_RATE_DIV && id <= FLD_SWITCHES)
         return id[4:0];
      else if (id >= FLD_ALARM_LO && id <= FLD_ALARM_HI)
         return 5'(id - FLD_ALARM_LO) + 5'd9;
      else
         return 5'h1F;
   endfunction

   function automatic logic orient_ok(input logic [15:0] v);
      unique case (v)
         16'h0000, 16'h0009, 16'h0023, 16'h002A, 16'h0041, 16'h0048,
         16'h0062, 16'h006B, 16'h0085, 16'h008C, 16'h0092, 16'h009B,
         16'h00C4, 16'h00CD, 16'h00D3, 16'h00DA, 16'h0111, 16'h0118,
         16'h0124, 16'h012D, 16'h0150, 16'h0159, 16'h0165, 16'h016C:
            return 1'b1;
         default:
            return 1'b0;
      endcase
   endfunction

   function automatic cutoff_e cutoff_of(input logic [15:0] v);
      if (v >= FILT_5HZ_MIN)       return CUT_5HZ;
      else if (v >= FILT_10HZ_MIN) return CUT_10HZ;
      else if (v >= FILT_20HZ_MIN) return CUT_20HZ;
      else                         return CUT_50HZ;
   endfunction

   // signed window check; alarm fields other than roll limits take any value
   function automatic logic value_ok(input logic [15:0] id, input logic [15:0] v,
                                     input logic pkt_ok);
      unique case (id)
         FLD_RATE_DIV:
            return v inside {16'd0, 16'd1, 16'd2, 16'd4, 16'd5, 16'd10, 16'd20,
                             16'd25, 16'd50};
         FLD_LINE_RATE:
            return v inside {16'd2, 16'd3, 16'd5, 16'd6};
         FLD_PKT_SEL:   return pkt_ok;
         FLD_UNUSED:    return 1'b0;
         FLD_ORIENT:    return orient_ok(v);
         FLD_ROLL_UP, FLD_ROLL_DN:
            return $signed(v) <= $signed(ROLL_MAX)
                && $signed(v) >= $signed(ROLL_MIN);
         default:       return 1'b1;
      endcase
   endfunction

   // request decode
   wire logic [4:0]  req_slot   = slot_of(set_req.field_id);
   wire logic        req_mapped = (req_slot != 5'h1F);
   wire logic        req_ok     = set_req.valid && req_mapped
                                  && value_ok(set_req.field_id, set_req.data, pkt_type_ok);
   wire logic        do_set     = req_ok && !set_req.persistent;
   wire logic        do_write   = req_ok && set_req.persistent;
   wire logic [4:0]  ld_slot    = slot_of(load_field_id);
   wire logic        do_load    = load_valid && ld_slot != 5'h1F;
   wire logic [4:0]  rd_slot    = slot_of(read_field_id);
   wire logic        rd_mapped  = rd_slot != 5'h1F && read_field_id != FLD_UNUSED;
   wire logic [15:0] rd_value   = !rd_mapped ? 16'h0000 :
                                  read_stored ? store_reg[rd_slot]
                                              : work_reg[rd_slot];

   wire logic [15:0] orient_w = work_reg[FLD_ORIENT[3:0]];
   wire logic [15:0] sw_w     = work_reg[FLD_SWITCHES[3:0]];
   wire logic        sw_free  = sw_w[SW_FREE_BIT];

   logic [CNT_W-1:0] free_cnt_reg;
   logic             free_run_reg;
   logic             free_arm_reg;

   wire logic             free_tick_end = (free_cnt_reg == FREE_LAST);
   wire logic             free_start    = sw_free && !free_arm_reg;
   // clearing the switch ends the run early
   wire logic             free_stop     = free_tick_end || !sw_free;
   wire logic             free_run_next = free_start || (free_run_reg && !free_stop);
   wire logic [CNT_W-1:0] free_cnt_next = free_start   ? '0 :
                                          free_run_reg ? free_cnt_reg + CNT_W'(1)
                                                       : free_cnt_reg;

   // storage arrays; power-up load writes both copies
   generate
      for (genvar i = 0; i < NUM_SLOTS; i++) begin : g_slot
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               work_reg[i]  <= (i == int'(FLD_ORIENT)) ? ORIENT_RST : 16'h0000;
               store_reg[i] <= (i == int'(FLD_ORIENT)) ? ORIENT_RST : 16'h0000;
            end else if (do_load && ld_slot == 5'(i)) begin
               work_reg[i]  <= load_data;
               store_reg[i] <= load_data;
            end else begin
               if (do_set && req_slot == 5'(i))
                  work_reg[i] <= set_req.data;
               if (do_write && req_slot == 5'(i))
                  store_reg[i] <= set_req.data;
            end
         end
      end
   endgenerate

   // free integration window: rising edge of switch starts a fixed run
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         free_arm_reg <= 1'b0;
      end else begin
         free_arm_reg <= sw_free;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         free_run_reg <= 1'b0;
      end else begin
         free_run_reg <= free_run_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         free_cnt_reg <= '0;
      end else begin
         free_cnt_reg <= free_cnt_next;
      end
   end

   // next values of the registered outputs
   wire field_rsp_s rsp_next = '{
      valid:    set_req.valid || read_req,
      ack:      set_req.valid ? req_ok : rd_mapped,
      field_id: set_req.valid ? set_req.field_id : read_field_id,
      data:     set_req.valid ? set_req.data : rd_value
   };
   wire logic        store_valid_next          = do_write;
   wire logic [15:0] store_field_id_next       = set_req.field_id;
   wire logic [15:0] store_data_next           = set_req.data;
   // strobe comes out in the same cycle as the answer; line_rate_code follows one cycle later
   wire logic        line_rate_change_next     = do_set
                                                 && set_req.field_id == FLD_LINE_RATE;
   wire logic [2:0]  line_rate_code_next       = work_reg[FLD_LINE_RATE[4:0]][2:0];
   wire logic        restart_req_next          = over_range && sw_w[SW_RESTART_BIT];
   wire logic        free_integrate_next       = free_run_reg;
   wire logic        high_gain_next            = !sw_w[SW_DYNAMIC_BIT];
   wire logic [15:0] rate_divider_next         = work_reg[FLD_RATE_DIV[4:0]];
   wire logic [15:0] packet_select_next        = work_reg[FLD_PKT_SEL[4:0]];
   wire cutoff_e     rate_filter_setting_next  = cutoff_of(work_reg[FLD_RATE_FILT[4:0]]);
   wire cutoff_e     accel_filter_setting_next = cutoff_of(work_reg[FLD_ACC_FILT[4:0]]);
   wire logic [15:0] roll_upper_next           = work_reg[ROLL_UP_SLOT];
   wire logic [15:0] roll_lower_next           = work_reg[ROLL_DN_SLOT];

   wire axis_map_s axis_map_next = '{
      x_neg: orient_w[0],
      x_src: sensor_axis_e'(orient_w[2:1]),
      y_neg: orient_w[3],
      // y and z codes are rotated so code 0 means the same-named axis
      y_src: sensor_axis_e'(rot(orient_w[5:4], 2'd1)),
      z_neg: orient_w[6],
      z_src: sensor_axis_e'(rot(orient_w[8:7], 2'd2))
   };

   // one short flop per output keeps every output straight from a register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp <= '0;
      end else begin
         rsp <= rsp_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         store_valid <= 1'b0;
      end else begin
         store_valid <= store_valid_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         store_field_id <= 16'h0000;
      end else begin
         store_field_id <= store_field_id_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         store_data <= 16'h0000;
      end else begin
         store_data <= store_data_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_rate_change <= 1'b0;
      end else begin
         line_rate_change <= line_rate_change_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         line_rate_code <= 3'h0;
      end else begin
         line_rate_code <= line_rate_code_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         restart_req <= 1'b0;
      end else begin
         restart_req <= restart_req_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         free_integrate <= 1'b0;
      end else begin
         free_integrate <= free_integrate_next;
      end
   end

   // reset level matches the cleared switch field: static, high gain
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         high_gain <= 1'b1;
      end else begin
         high_gain <= high_gain_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rate_divider <= 16'h0000;
      end else begin
         rate_divider <= rate_divider_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         packet_select <= 16'h0000;
      end else begin
         packet_select <= packet_select_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rate_filter_setting <= CUT_50HZ;
      end else begin
         rate_filter_setting <= rate_filter_setting_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         accel_filter_setting <= CUT_50HZ;
      end else begin
         accel_filter_setting <= accel_filter_setting_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         axis_map <= '0;
      end else begin
         axis_map <= axis_map_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         roll_upper <= 16'h0000;
      end else begin
         roll_upper <= roll_upper_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         roll_lower <= 16'h0000;
      end else begin
         roll_lower <= roll_lower_next;
      end
   end

   function automatic logic [1:0] rot(input logic [1:0] code, input logic [1:0] base);
      logic [2:0] s;
      s = 3'(code) + 3'(base);
      if (code == 2'd3)
         return 2'd3;  // invalid code stored only by a power-up load; set and write reject it
      return (s >= 3'd3) ? 2'(s - 3'd3) : s[1:0];
   endfunction
endmodule
`default_nettype wire

/* File: verif/cfg_bank_monitor.sv */
// checker for the configuration field bank ports
`timescale 1ns/100ps
`default_nettype none
module cfg_bank_monitor import cfg_field_pkg::*; (
   // clock and reset
   input wire logic       clk,
   input wire logic       rst_b,
   // requests and answers
   input wire field_req_s set_req,
   input wire field_rsp_s rsp,
   input wire logic       store_valid,
   input wire logic       over_range,
   // decoded outputs
   input wire logic       restart_req,
   input wire logic       line_rate_change,
   input wire logic [2:0] line_rate_code,
   input wire cutoff_e    rate_filter_setting,
   input wire axis_map_s  axis_map,
   input wire logic       high_gain
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire        req_on  = set_req.valid;
   wire        set_now = req_on && !set_req.persistent;
   wire [15:0] id      = set_req.field_id;
   wire [15:0] d       = set_req.data;
   property p_unused_nak; req_on && id == FLD_UNUSED |=> rsp.valid && !rsp.ack; endproperty
   a_unused_nak: assert property (p_unused_nak) else $error("unused field accepted");
   property p_orient_rsvd; req_on && id == FLD_ORIENT && d[15:9] != 0 |=> !rsp.ack; endproperty
   a_orient_rsvd: assert property (p_orient_rsvd) else $error("reserved bits accepted");
   property p_rate_now; set_now && id == FLD_LINE_RATE && d == 16'h0005
      |=> line_rate_change ##1 line_rate_code == 3'd5; endproperty
   a_rate_now: assert property (p_rate_now) else $error("line rate not immediate");
   property p_rate_bad; req_on && id == FLD_LINE_RATE && d == 16'h0004 |=> !rsp.ack; endproperty
   a_rate_bad: assert property (p_rate_bad) else $error("bad line rate accepted");
   property p_filt; set_now && id == FLD_RATE_FILT && d >= FILT_5HZ_MIN
      |=> ##1 rate_filter_setting == CUT_5HZ; endproperty
   a_filt: assert property (p_filt) else $error("filter not 5 Hz");
   property p_orient_zero; set_now && id == FLD_ORIENT && d == 16'h0000
      |=> ##1 9'(axis_map) == 9'h00A; endproperty
   a_orient_zero: assert property (p_orient_zero) else $error("identity map wrong");
   property p_no_restart; !over_range |=> !restart_req; endproperty
   a_no_restart: assert property (p_no_restart) else $error("restart without cause");
   property p_dynamic; set_now && id == FLD_SWITCHES && d[5] |=> ##1 !high_gain; endproperty
   a_dynamic: assert property (p_dynamic) else $error("high gain kept");
   property p_store; req_on && set_req.persistent && id == FLD_LINE_RATE && d == 16'h0003
      |=> store_valid; endproperty
   a_store: assert property (p_store) else $error("write not stored");
   c_nak: cover property (rsp.valid && !rsp.ack);
   c_store: cover property (store_valid);
   c_restart: cover property (restart_req);
endmodule
bind sensor_config_field_bank cfg_bank_monitor mon (
   .clk(clk), .rst_b(rst_b), .set_req(set_req), .rsp(rsp), .store_valid(store_valid),
   .over_range(over_range), .restart_req(restart_req), .line_rate_change(line_rate_change),
   .line_rate_code(line_rate_code), .rate_filter_setting(rate_filter_setting),
   .axis_map(axis_map), .high_gain(high_gain));
`default_nettype wire

/* File: verif/cfg_host.sv */
// host model issuing field set, write and read requests
`timescale 1ns/100ps
`default_nettype none
module cfg_host import cfg_field_pkg::*; (
   // clock
   input wire logic    clk,
   // requests
   output field_req_s  set_req,
   output logic        read_req,
   output logic        read_stored,
   output logic [15:0] read_field_id,
   // answer
   input wire field_rsp_s rsp
);
   initial begin
      set_req = '0;
      read_req = 1'b0;
      read_stored = 1'b0;
      read_field_id = 16'h0000;
   end
   // kind: 0 set, 1 write, 2 read working, 3 read stored
   task automatic xfer(input logic [1:0] kind, input logic [15:0] id, data,
                       output logic got, ack, output logic [15:0] rdata);
      @(posedge clk);
      #2;
      set_req = '{~kind[1], kind[0], id, data};
      read_req = kind[1];
      read_stored = kind[0];
      read_field_id = id;
      @(posedge clk);
      #2;
      set_req.valid = 1'b0;
      read_req = 1'b0;
      // released lines must not keep showing the last value
      set_req.data = ~data;
      read_field_id = ~id;
      got = rsp.valid;
      ack = rsp.ack;
      rdata = rsp.data;
   endtask
endmodule
`default_nettype wire

/* File: verif/test_sensor_config_field_bank.sv */
// self-checking bench for the configuration field bank
`timescale 1ns/100ps
`default_nettype none
module test_sensor_config_field_bank import cfg_field_pkg::*;;
   typedef struct packed {logic [15:0] id, data; logic ack; logic [15:0] rb;} row_s;
   logic clk, rst_b, load_valid, pkt_type_ok, over_range, read_req, read_stored;
   logic line_rate_change, free_integrate, restart_req, high_gain, store_valid, got, ack;
   logic [15:0] load_field_id, load_data, read_field_id, store_field_id, store_data, rd;
   logic [15:0] rate_divider, packet_select, roll_upper, roll_lower, v;
   logic [2:0] line_rate_code;
   field_req_s set_req;
   field_rsp_s rsp;
   cutoff_e rate_filter_setting, accel_filter_setting;
   axis_map_s axis_map;
   int mismatches = 0, checks = 0, n;
   row_s rows [15] = '{'{FLD_RATE_DIV, 16'h000A, 1, 16'h000A},
      '{FLD_RATE_DIV, 16'h0003, 0, 16'h000A}, '{FLD_LINE_RATE, 16'h0002, 1, 16'h0002},
      '{FLD_LINE_RATE, 16'h0006, 1, 16'h0006}, '{FLD_LINE_RATE, 16'h0005, 1, 16'h0005},
      '{FLD_LINE_RATE, 16'h0004, 0, 16'h0005}, '{FLD_UNUSED, 16'h0001, 0, 16'h0000},
      '{FLD_ORIENT, 16'h016D, 0, 16'h0009}, '{FLD_ORIENT, 16'h0200, 0, 16'h0009},
      '{FLD_ROLL_UP, 16'h0019, 1, 16'h0019}, '{FLD_ROLL_UP, 16'h001A, 0, 16'h0019},
      '{FLD_ROLL_DN, 16'hFFE7, 1, 16'hFFE7}, '{FLD_ROLL_DN, 16'hFFE6, 0, 16'hFFE7},
      '{FLD_RATE_FILT, 16'hFFFF, 1, 16'hFFFF}, '{FLD_ACC_FILT, 16'h0000, 1, 16'h0000}};
   logic [15:0] orient [24] = '{16'h0000, 16'h0009, 16'h0023, 16'h002A, 16'h0041, 16'h0048,
      16'h0062, 16'h006B, 16'h0085, 16'h008C, 16'h0092, 16'h009B, 16'h00C4, 16'h00CD,
      16'h00D3, 16'h00DA, 16'h0111, 16'h0118, 16'h0124, 16'h012D, 16'h0150, 16'h0159,
      16'h0165, 16'h016C};
   logic [15:0] fval [6] = '{16'h1BE6, 16'h1BE5, 16'h0DF3, 16'h0DF2, 16'h05FA, 16'h05F9};
   cutoff_e fcut [6] = '{CUT_5HZ, CUT_10HZ, CUT_10HZ, CUT_20HZ, CUT_20HZ, CUT_50HZ};
   // short free-run count keeps the run brief
   sensor_config_field_bank #(.FREE_RUN_CYCLES(20)) DUT (.clk, .rst_b, .load_valid,
      .load_field_id, .load_data, .set_req, .read_req, .read_stored, .read_field_id, .rsp,
      .store_valid, .store_field_id, .store_data, .pkt_type_ok, .over_range, .rate_divider,
      .line_rate_code, .line_rate_change, .packet_select, .rate_filter_setting,
      .accel_filter_setting, .axis_map, .free_integrate, .restart_req, .high_gain,
      .roll_upper, .roll_lower);
   cfg_host host (.clk, .set_req, .read_req, .read_stored, .read_field_id, .rsp);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      if (mismatches == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic step();
      @(posedge clk);
      #2;
   endtask
   task automatic op(input logic [1:0] kind, input logic [15:0] id, data);
      host.xfer(kind, id, data, got, ack, rd);
      if (got !== 1'b1) begin
         mismatches++;
         $display("mismatch at %0t: no answer", $time);
         conclude();
      end
   endtask
   initial begin
      {rst_b, load_valid, over_range, load_field_id, load_data} = '0;
      pkt_type_ok = 1'b1;
      repeat (10) @(posedge clk);
      #2 rst_b = 1'b1;
      step();
      check(16'(axis_map), 16'h012A);
      check(16'(high_gain), 16'h0001);
      op(2'd2, FLD_ORIENT, 16'h0000);
      check(rd, ORIENT_RST);
      foreach (rows[i]) begin
         op(2'd0, rows[i].id, rows[i].data);
         check(16'(ack), 16'(rows[i].ack));
         op(2'd2, rows[i].id, 16'h0000);
         check(rd, rows[i].rb);
      end
      op(2'd0, FLD_ALARM_HI, 16'h0007);
      check(16'(ack), 16'h0001);
      op(2'd2, FLD_ALARM_HI, 16'h0000);
      check(rd, 16'h0007);
      check(rate_divider, 16'h000A);
      check(roll_upper, 16'h0019);
      check(roll_lower, 16'hFFE7);
      check(16'(line_rate_code), 16'h0005);
      foreach (orient[i]) begin
         v = orient[i];
         op(2'd0, FLD_ORIENT, v);
         check(16'(ack), 16'h0001);
         step();
         check(16'(axis_map), 16'({v[0], v[2:1], v[3], 2'((v[5:4] + 1) % 3),
               v[6], 2'((v[8:7] + 2) % 3)}));
      end
      foreach (fval[i]) begin
         op(2'd0, FLD_RATE_FILT, fval[i]);
         op(2'd0, FLD_ACC_FILT, fval[i]);
         step();
         check(16'(rate_filter_setting), 16'(fcut[i]));
         check(16'(accel_filter_setting), 16'(fcut[i]));
      end
      pkt_type_ok = 1'b0;
      op(2'd0, FLD_PKT_SEL, 16'h1234);
      check(16'(ack), 16'h0000);
      pkt_type_ok = 1'b1;
      op(2'd0, FLD_PKT_SEL, 16'h1234);
      step();
      check(packet_select, 16'h1234);
      op(2'd0, FLD_SWITCHES, 16'h0031);
      step();
      check(16'(high_gain), 16'h0000);
      check(16'(free_integrate), 16'h0000);
      over_range = 1'b1;
      step();
      over_range = 1'b0;
      check(16'(restart_req), 16'h0001);
      check(16'(free_integrate), 16'h0001);
      for (n = 0; n < 40 && free_integrate; n++) step();
      check(16'(n), 16'h0014);
      op(2'd0, FLD_SWITCHES, 16'h0000);
      step();
      over_range = 1'b1;
      step();
      over_range = 1'b0;
      check(16'(restart_req), 16'h0000);
      check(16'(high_gain), 16'h0001);
      op(2'd1, FLD_LINE_RATE, 16'h0003);
      check(16'(store_valid), 16'h0001);
      check(store_data, 16'h0003);
      check(store_field_id, FLD_LINE_RATE);
      op(2'd3, FLD_LINE_RATE, 16'h0000);
      check(rd, 16'h0003);
      op(2'd2, FLD_LINE_RATE, 16'h0000);
      check(rd, 16'h0005);
      {load_valid, load_field_id, load_data} = {1'b1, FLD_RATE_DIV, 16'h0032};
      step();
      load_valid = 1'b0;
      op(2'd2, FLD_RATE_DIV, 16'h0000);
      check(rd, 16'h0032);
      rst_b = 1'b0;
      step();
      rst_b = 1'b1;
      step();
      check(16'(axis_map), 16'h012A);
      conclude();
   end
endmodule
`default_nettype wire
